//--- src/bod_pkg.sv
/*
 Shared constants and types for the byte-oriented instruction decoder.
 Assumes 16-bit program words and an 8-bit datapath behind the decoder.
*/
`default_nettype none
package bod_pkg;
  // ------------------------------------------------------------
  // word layout
  // ------------------------------------------------------------
  localparam int WORD_W        = 16;
  localparam int FILE_W        = 8;
  localparam int FAR_W         = 12;
  localparam int TARGET_W      = 20;
  localparam int OFF_LONG_W    = 11;
  localparam int BITPOS_W      = 3;
  localparam int DEST_BIT      = 9;
  localparam int BANK_BIT      = 8;
  localparam int BITPOS_LSB    = 9;
  localparam int FAST_BIT      = 8;
  localparam logic [3:0] PREFIX_SECOND = 4'hF;
  localparam logic [3:0] PREFIX_MOVE   = 4'hC;
  localparam logic [WORD_W-1:0] WORD_NOP = 16'h0000;

  // ------------------------------------------------------------
  // status flag mask, one bit per flag
  // ------------------------------------------------------------
  localparam int FLAG_N_W = 5;
  localparam logic [FLAG_N_W-1:0] FLG_C     = 5'h01;
  localparam logic [FLAG_N_W-1:0] FLG_DC    = 5'h02;
  localparam logic [FLAG_N_W-1:0] FLG_Z     = 5'h04;
  localparam logic [FLAG_N_W-1:0] FLG_OV    = 5'h08;
  localparam logic [FLAG_N_W-1:0] FLG_N     = 5'h10;
  localparam logic [FLAG_N_W-1:0] FLG_NONE  = 5'h00;
  localparam logic [FLAG_N_W-1:0] FLG_ARITH = FLG_C | FLG_DC | FLG_Z
                                            | FLG_OV | FLG_N;
  localparam logic [FLAG_N_W-1:0] FLG_ZN    = FLG_Z | FLG_N;
  localparam logic [FLAG_N_W-1:0] FLG_CZN   = FLG_C | FLG_Z | FLG_N;

  // ------------------------------------------------------------
  // decoded operations
  // ------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_NOP, OP_ADD, OP_ADDC, OP_AND, OP_OR, OP_XOR, OP_COM, OP_MUL,
    OP_RLC, OP_RLN, OP_RRC, OP_RRN, OP_CPEQ, OP_CPGT, OP_CPLT,
    OP_DECSZ, OP_DECSNZ, OP_INCSZ, OP_INCSNZ, OP_SUB, OP_SUBB,
    OP_SUBRB, OP_MOVE, OP_GOTO, OP_CALL, OP_BRA, OP_BCOND, OP_OTHER
  } bod_op_t;

  // gray along exec -> word2 / exec -> flush; exec -> flush2 flips both bits
  typedef enum logic [1:0] {
    ST_EXEC   = 2'h0,
    ST_WORD2  = 2'h1,
    ST_FLUSH  = 2'h2,
    ST_FLUSH2 = 2'h3
  } bod_state_t;

  localparam logic [FILE_W-1:0] ADDR_RST = 8'h00;
endpackage : bod_pkg
`default_nettype wire

//--- src/bod_fields.sv
/*
 Operand field extraction, the same for every word format.
 Assumes a word straight from program memory; purely combinational.
*/
`timescale 1ns/10ps
`default_nettype none
module bod_fields (
  // word in
  input  wire logic [bod_pkg::WORD_W-1:0]     word,
  // operand fields
  output logic [bod_pkg::FILE_W-1:0]          file_addr,
  output logic                                dest_bit,
  output logic                                bank_bit,
  output logic [bod_pkg::BITPOS_W-1:0]        bit_pos,
  output logic [bod_pkg::FILE_W-1:0]          literal,
  output logic [bod_pkg::FAR_W-1:0]           far_field,
  output logic [bod_pkg::OFF_LONG_W-1:0]      off_long,
  output logic [bod_pkg::FILE_W-1:0]          off_short,
  output logic                                fast_bit
);
  import bod_pkg::*;

  // every field is cut for every word; consumers pick
  assign file_addr = word[FILE_W-1:0];
  assign dest_bit  = word[DEST_BIT];
  assign bank_bit  = word[BANK_BIT];
  assign bit_pos   = word[BITPOS_LSB +: BITPOS_W];
  assign literal   = word[FILE_W-1:0];
  assign far_field = word[FAR_W-1:0];
  assign off_long  = word[OFF_LONG_W-1:0];
  assign off_short = word[FILE_W-1:0];
  assign fast_bit  = word[FAST_BIT];
endmodule : bod_fields
`default_nettype wire

//--- src/bod_op_table.sv
/*
 Opcode classification of one program word.
 Assumes the word is a first word; second words are sorted out upstream.
*/
`timescale 1ns/10ps
`default_nettype none
module bod_op_table (
  // word in
  input  wire logic [bod_pkg::WORD_W-1:0]    word,
  // classification
  output bod_pkg::bod_op_t                   op,
  output logic [bod_pkg::FLAG_N_W-1:0]       flags,
  output logic                               cond_op,
  output logic                               two_word,
  output logic                               has_dest,
  output logic                               self_mod
);
  import bod_pkg::*;

  always_comb begin
    op       = OP_OTHER;
    flags    = FLG_NONE;
    cond_op  = 1'b0;
    has_dest = 1'b1;
    self_mod = 1'b1;
    casez (word[15:8])
      8'b0010_01??: begin op = OP_ADD;  flags = FLG_ARITH; end
      8'b0010_00??: begin op = OP_ADDC; flags = FLG_ARITH; end
      8'b0001_00??: begin op = OP_OR;   flags = FLG_ZN; end
      8'b0001_01??: begin op = OP_AND;  flags = FLG_ZN; end
      8'b0001_10??: begin op = OP_XOR;  flags = FLG_ZN; end
      8'b0001_11??: begin op = OP_COM;  flags = FLG_ZN; end
      8'b0000_001?: begin op = OP_MUL;  has_dest = 1'b0; end
      8'b0011_01??: begin op = OP_RLC;  flags = FLG_CZN; end
      8'b0100_01??: begin op = OP_RLN;  flags = FLG_ZN; end
      8'b0011_00??: begin op = OP_RRC;  flags = FLG_CZN; end
      8'b0100_00??: begin op = OP_RRN;  flags = FLG_ZN; end
      8'b0110_001?: begin
        op = OP_CPEQ; cond_op = 1'b1; has_dest = 1'b0;
        self_mod = 1'b0;
      end
      8'b0110_010?: begin
        op = OP_CPGT; cond_op = 1'b1; has_dest = 1'b0;
        self_mod = 1'b0;
      end
      8'b0110_000?: begin
        op = OP_CPLT; cond_op = 1'b1; has_dest = 1'b0;
        self_mod = 1'b0;
      end
      8'b0010_11??: begin op = OP_DECSZ;  cond_op = 1'b1; end
      8'b0100_11??: begin op = OP_DECSNZ; cond_op = 1'b1; end
      8'b0011_11??: begin op = OP_INCSZ;  cond_op = 1'b1; end
      8'b0100_10??: begin op = OP_INCSNZ; cond_op = 1'b1; end
      8'b0101_11??: begin op = OP_SUB;   flags = FLG_ARITH; end
      8'b0101_10??: begin op = OP_SUBB;  flags = FLG_ARITH; end
      8'b0101_01??: begin op = OP_SUBRB; flags = FLG_ARITH; end
      8'b1100_????: op = OP_MOVE;
      8'b1110_1111: op = OP_GOTO;
      8'b1110_110?: op = OP_CALL;
      8'b1101_0???: op = OP_BRA;
      8'b1110_0???: begin op = OP_BCOND; cond_op = 1'b1; end
      8'b1111_????: op = OP_NOP;
      default:      op = OP_OTHER;
    endcase
    if (word == WORD_NOP)
      op = OP_NOP;
    if (op inside {OP_MOVE, OP_GOTO, OP_CALL, OP_BRA, OP_BCOND, OP_NOP,
                   OP_OTHER}) begin
      has_dest = 1'b0;
      self_mod = 1'b0;
    end
  end

  assign two_word = (op == OP_MOVE) || (op == OP_GOTO) || (op == OP_CALL);
endmodule : bod_op_table
`default_nettype wire

//--- src/bod_decoder.sv
/*
 Top of the byte-oriented instruction decoder: sequences first and second
 words, flushes after branches and taken skips, registers all controls.
 Assumes program memory offers one word per cycle with word_valid, and the
 datapath reports a taken test on cond_true in the same cycle that issue is high.
*/
// What this block does
// - destination bit clear sends result to accumulator, set to register.
// - bank bit clear forces access bank, set uses bank select register.
// - two-word move takes 12-bit source, then 12-bit destination word.
// - bit operations expose a 3-bit bit position field.
// - literal operand is the low byte of the word.
// - goto and call build a 20-bit target from both words.
// - call first word carries a fast-mode bit passed to call logic.
// - always-branch uses 11-bit offset, conditional branches 8-bit.
// - add forms decode under 0010 and update all arithmetic flags.
// - logical forms decode under 0001 and update zero and negative.
// - multiply decodes as 0000 001a and alters no flags.
// - rotates decode under 0011/0100; through-carry forms update C, Z, N.
// - compare-and-skip forms decode under 0110 and alter no flags.
// - counting skips decode as listed and leave flags unchanged.
// - subtract forms decode under 0101 and update arithmetic flags.
// - always-branch or taken test costs a second cycle run as a no-op.
// - a lone second word executes as a no-op.
// - read-modify-write on a port register reads the pins.
// - qualifying op on the timer count clears an assigned prescaler.
// - call with fast bit set saves shadow registers, else untouched.
`timescale 1ns/10ps
`default_nettype none
module bod_decoder #(
  parameter logic [7:0] TIMER_ADDR = 8'h00,
  parameter logic [7:0] PORT_LO    = 8'h80,
  parameter logic [7:0] PORT_HI    = 8'h8F
) (
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              reset_n,
  // program memory side
  input  wire logic [bod_pkg::WORD_W-1:0]        word,
  input  wire logic                              word_valid,
  // datapath feedback
  input  wire logic                              cond_true,
  input  wire logic                              prescaler_assigned,
  // decoded operation
  output logic                                   issue,
  output bod_pkg::bod_op_t                       op,
  output logic [bod_pkg::FLAG_N_W-1:0]           flags_upd,
  output logic                                   cond_op,
  // operand fields
  output logic                                   dest_to_reg,
  output logic                                   use_bank_sel,
  output logic [bod_pkg::FILE_W-1:0]             file_addr,
  output logic [bod_pkg::BITPOS_W-1:0]           bit_pos,
  output logic [bod_pkg::FILE_W-1:0]             literal,
  output logic [bod_pkg::OFF_LONG_W-1:0]         branch_off_long,
  output logic [bod_pkg::FILE_W-1:0]             branch_off_short,
  // two-word results
  output logic [bod_pkg::FAR_W-1:0]              move_src,
  output logic [bod_pkg::FAR_W-1:0]              move_dst,
  output logic [bod_pkg::TARGET_W-1:0]           jump_target,
  output logic                                   call_fast,
  output logic                                   shadow_save,
  // side effects
  output logic                                   read_from_pins,
  output logic                                   prescaler_clear
);
  import bod_pkg::*;

  // an empty port window would make the pin-read decode dead logic
  if (PORT_LO > PORT_HI) begin : g_bad_port_range
    $error("port range is empty");
  end

  // ------------------------------------------------------------
  // word classification
  // ------------------------------------------------------------
  bod_op_t                 w_op;
  logic [FLAG_N_W-1:0]     w_flags;
  logic                    w_cond;
  logic                    w_two;
  logic                    w_has_dest;
  logic                    w_self_mod;
  logic [FILE_W-1:0]       w_file;
  logic                    w_dest;
  logic                    w_bank;
  logic [BITPOS_W-1:0]     w_bitpos;
  logic [FILE_W-1:0]       w_lit;
  logic [FAR_W-1:0]        w_far;
  logic [OFF_LONG_W-1:0]   w_off_long;
  logic [FILE_W-1:0]       w_off_short;
  logic                    w_fast;

  bod_op_table u_table (
    .word     (word),
    .op       (w_op),
    .flags    (w_flags),
    .cond_op  (w_cond),
    .two_word (w_two),
    .has_dest (w_has_dest),
    .self_mod (w_self_mod)
  );

  bod_fields u_fields (
    .word      (word),
    .file_addr (w_file),
    .dest_bit  (w_dest),
    .bank_bit  (w_bank),
    .bit_pos   (w_bitpos),
    .literal   (w_lit),
    .far_field (w_far),
    .off_long  (w_off_long),
    .off_short (w_off_short),
    .fast_bit  (w_fast)
  );

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    bod_state_t            fsm;
    logic                  flush_pend;
    logic                  issue;
    bod_op_t               op;
    logic [FLAG_N_W-1:0]   flags;
    logic                  cond_op;
    logic                  dest_to_reg;
    logic                  use_bank_sel;
    logic [FILE_W-1:0]     file_addr;
    logic [BITPOS_W-1:0]   bit_pos;
    logic [FILE_W-1:0]     literal;
    logic [OFF_LONG_W-1:0] off_long;
    logic [FILE_W-1:0]     off_short;
    logic [FAR_W-1:0]      move_src;
    logic [FAR_W-1:0]      move_dst;
    logic [TARGET_W-1:0]   target;
    logic                  call_fast;
    logic                  shadow_save;
    logic                  read_pins;
    logic                  presc_clear;
    bod_op_t               held_op;
  } bod_regs_t;

  bod_regs_t s_q;
  bod_regs_t s_d;
  logic      flush_now;
  logic      in_port;

  // a taken test flushes the word that arrives alongside or next
  assign flush_now = s_q.flush_pend
                   | (s_q.issue & s_q.cond_op & cond_true);
  assign in_port   = !w_bank && (w_file >= PORT_LO)
                   && (w_file <= PORT_HI);

  always_comb begin
    s_d             = s_q;
    s_d.issue       = 1'b0;
    s_d.shadow_save = 1'b0;
    s_d.presc_clear = 1'b0;
    s_d.read_pins   = 1'b0;
    if (!word_valid) begin
      // stalled fetch must not lose a taken test
      s_d.flush_pend = flush_now;
    end else begin
      s_d.flush_pend = 1'b0;
      unique case (s_q.fsm)
        ST_EXEC: begin
          if (flush_now) begin
            s_d.issue   = 1'b1;
            s_d.op      = OP_NOP;
            s_d.flags   = FLG_NONE;
            s_d.cond_op = 1'b0;
            // skipping a two-word op costs a third cycle
            if (w_two)
              s_d.fsm = ST_FLUSH2;
          end else begin
            s_d.dest_to_reg  = w_dest;
            s_d.use_bank_sel = w_bank;
            s_d.file_addr    = w_file;
            s_d.bit_pos      = w_bitpos;
            s_d.literal      = w_lit;
            s_d.off_long     = w_off_long;
            s_d.off_short    = w_off_short;
            if (w_two) begin
              s_d.held_op   = w_op;
              s_d.move_src  = w_far;
              s_d.target    = {{(TARGET_W-FILE_W){1'b0}}, w_lit};
              s_d.call_fast = w_fast && (w_op == OP_CALL);
              s_d.fsm       = ST_WORD2;
            end else begin
              s_d.issue   = 1'b1;
              s_d.op      = w_op;
              s_d.flags   = w_flags;
              s_d.cond_op = w_cond;
              // port writes back what the pins show
              s_d.read_pins = w_self_mod && in_port
                            && (!w_has_dest || w_dest);
              // timer count write resets its prescaler
              s_d.presc_clear = w_self_mod && prescaler_assigned
                              && !w_bank && (w_file == TIMER_ADDR)
                              && (!w_has_dest || w_dest);
              if (w_op == OP_BRA)
                s_d.fsm = ST_FLUSH;
            end
          end
        end
        ST_WORD2: begin
          s_d.issue   = 1'b1;
          s_d.flags   = FLG_NONE;
          s_d.cond_op = 1'b0;
          s_d.fsm     = ST_EXEC;
          if (word[WORD_W-1 -: 4] == PREFIX_SECOND) begin
            s_d.op = s_q.held_op;
            if (s_q.held_op == OP_MOVE)
              s_d.move_dst = w_far;
            else
              s_d.target = {w_far, s_q.target[FILE_W-1:0]};
            // fast call saves shadows, plain call leaves them
            s_d.shadow_save = (s_q.held_op == OP_CALL) && s_q.call_fast;
          end else begin
            // broken pair: run as no-op rather than guess
            s_d.op        = OP_NOP;
            s_d.call_fast = 1'b0;
          end
        end
        ST_FLUSH, ST_FLUSH2: begin
          // discarded word runs as a no-op
          s_d.issue   = 1'b1;
          s_d.op      = OP_NOP;
          s_d.flags   = FLG_NONE;
          s_d.cond_op = 1'b0;
          s_d.fsm     = ST_EXEC;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      s_q              <= '0;
      s_q.fsm          <= ST_EXEC;
      s_q.op           <= OP_NOP;
      s_q.held_op      <= OP_NOP;
      s_q.file_addr    <= ADDR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign issue            = s_q.issue;
  assign op               = s_q.op;
  assign flags_upd        = s_q.flags;
  assign cond_op          = s_q.cond_op;
  assign dest_to_reg      = s_q.dest_to_reg;
  assign use_bank_sel     = s_q.use_bank_sel;
  assign file_addr        = s_q.file_addr;
  assign bit_pos          = s_q.bit_pos;
  assign literal          = s_q.literal;
  assign branch_off_long  = s_q.off_long;
  assign branch_off_short = s_q.off_short;
  assign move_src         = s_q.move_src;
  assign move_dst         = s_q.move_dst;
  assign jump_target      = s_q.target;
  assign call_fast        = s_q.call_fast;
  assign shadow_save      = s_q.shadow_save;
  assign read_from_pins   = s_q.read_pins;
  assign prescaler_clear  = s_q.presc_clear;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  logic normal_take;
  assign normal_take = word_valid && (s_q.fsm == ST_EXEC) && !flush_now;

  chk_dest_route: assert property (normal_take && !w_two |=>
    dest_to_reg == $past(word[DEST_BIT]) && issue)
    else $error("destination bit not routed");
  chk_bank_route: assert property (normal_take |=>
    use_bank_sel == $past(word[BANK_BIT])
    && file_addr == $past(word[FILE_W-1:0]))
    else $error("bank bit or file address wrong");
  chk_move_pair: assert property (normal_take && w_op == OP_MOVE
    ##1 word_valid && word[15:12] == PREFIX_SECOND
    |=> op == OP_MOVE && issue && move_dst == $past(word[FAR_W-1:0])
    && move_src == $past(move_src))
    else $error("move pair fields wrong");
  chk_jump_high: assert property (s_q.fsm == ST_WORD2 && word_valid
    && word[15:12] == PREFIX_SECOND && s_q.held_op != OP_MOVE
    |=> jump_target[TARGET_W-1:FILE_W] == $past(word[FAR_W-1:0]))
    else $error("jump target high bits wrong");
  chk_shadow_fast: assert property (shadow_save |->
    call_fast && op == OP_CALL && issue)
    else $error("shadow save without fast call");
  chk_bra_state: assert property (issue && op == OP_BRA
    |-> s_q.fsm == ST_FLUSH)
    else $error("branch did not arm the flush");
  chk_bra_flush: assert property (s_q.fsm == ST_FLUSH
    && word_valid |=> issue && op == OP_NOP && flags_upd == FLG_NONE)
    else $error("branch not followed by no-op");
  chk_skip_flush: assert property (issue && cond_op && cond_true
    && word_valid |=> issue && op == OP_NOP && flags_upd == FLG_NONE)
    else $error("taken test did not flush");
  chk_lone_second: assert property (normal_take
    && word[15:12] == PREFIX_SECOND |=> issue && op == OP_NOP)
    else $error("lone second word not a no-op");
  chk_pins_port: assert property (read_from_pins |->
    !use_bank_sel && file_addr >= PORT_LO && file_addr <= PORT_HI)
    else $error("pin read outside port range");
  chk_presc_timer: assert property (prescaler_clear |->
    file_addr == TIMER_ADDR && !use_bank_sel && $past(prescaler_assigned))
    else $error("prescaler cleared off timer");
  chk_mul_flags: assert property (issue && op == OP_MUL |->
    flags_upd == FLG_NONE)
    else $error("multiply touched flags");
  chk_logic_flags: assert property (issue && op inside {OP_AND, OP_OR,
    OP_XOR, OP_COM} |-> flags_upd == FLG_ZN)
    else $error("logical op flags wrong");

  cov_skip_two_word: cover property (flush_now && word_valid && w_two
    ##1 word_valid);
  cov_fast_call: cover property (shadow_save);
  cov_bra: cover property (issue && op == OP_BRA ##1 word_valid);
endmodule : bod_decoder
`default_nettype wire

//--- testbench/bod_prog_mem.sv
/*
 Program memory model: hands queued words to the decoder, one a cycle.
 Assumes the bench fills q and drives stall.
*/
`timescale 1ns/10ps
`default_nettype none
module bod_prog_mem (
  // clock, reset, pacing
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        stall,
  // word out
  output var  logic [15:0] word,
  output var  logic        word_valid
);
  logic [15:0] q[$];
  initial word = 16'h0000;
  initial word_valid = 1'b0;
  // idle word flips each cycle so a stale word never looks held
  always @(posedge sys_clk) begin
    if (!reset_n) q.delete();
    if (!reset_n || stall || q.size() == 0) begin
      word_valid <= 1'b0;
      word       <= ~word;
    end else begin
      word_valid <= 1'b1;
      word       <= q.pop_front();
    end
  end
endmodule : bod_prog_mem
`default_nettype wire

//--- testbench/bod_decoder_bench.sv
/*
 Bench for bod_decoder: random words through the memory model, a cycle
 model predicting every issue. Assumes default decoder parameters.
*/
`timescale 1ns/10ps
`default_nettype none
module bod_decoder_bench;
  import bod_pkg::*;
  logic sys_clk, reset_n = 0, stall = 0, cond_true = 0;
  logic prescaler_assigned = 0, word_valid, issue, cond_op, dest_to_reg;
  logic use_bank_sel, call_fast, shadow_save, read_from_pins;
  logic prescaler_clear, e_iss, e_ss, e_rp, e_pc, e_sw, e_cond, fl, qual;
  logic [15:0] word, e_w, e_f;
  logic [7:0] file_addr, literal, branch_off_short;
  logic [4:0] flags_upd, e_fl;
  logic [2:0] bit_pos;
  logic [10:0] branch_off_long;
  logic [11:0] move_src, move_dst;
  logic [19:0] jump_target;
  bod_op_t op, e_op;
  int fail_count = 0, cmp_count = 0, st, idx;
  // first 17 entries carry a destination bit
  logic [7:0] hi_t[21] = '{8'h24, 8'h20, 8'h14, 8'h10, 8'h18, 8'h1C, 8'h34,
    8'h44, 8'h30, 8'h40, 8'h2C, 8'h4C, 8'h3C, 8'h48, 8'h5C, 8'h58, 8'h54,
    8'h02, 8'h62, 8'h64, 8'h60};
  bod_op_t op_t[21] = '{OP_ADD, OP_ADDC, OP_AND, OP_OR, OP_XOR, OP_COM,
    OP_RLC, OP_RLN, OP_RRC, OP_RRN, OP_DECSZ, OP_DECSNZ, OP_INCSZ,
    OP_INCSNZ, OP_SUB, OP_SUBB, OP_SUBRB, OP_MUL, OP_CPEQ, OP_CPGT, OP_CPLT};
  logic [4:0] fl_t[21] = '{5'h1F, 5'h1F, 5'h14, 5'h14, 5'h14, 5'h14, 5'h15,
    5'h14, 5'h15, 5'h14, 5'h00, 5'h00, 5'h00, 5'h00, 5'h1F, 5'h1F, 5'h1F,
    5'h00, 5'h00, 5'h00, 5'h00};
  bod_prog_mem i_bod_prog_mem (.sys_clk, .reset_n, .stall, .word,
    .word_valid);
  bod_decoder i_bod_decoder (.sys_clk, .reset_n, .word, .word_valid,
    .cond_true, .prescaler_assigned, .issue, .op, .flags_upd, .cond_op,
    .dest_to_reg, .use_bank_sel, .file_addr, .bit_pos, .literal,
    .branch_off_long, .branch_off_short, .move_src, .move_dst, .jump_target,
    .call_fast, .shadow_save, .read_from_pins, .prescaler_clear);
  initial begin sys_clk = 0; forever #20 sys_clk = ~sys_clk; end
  task automatic chk(input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic two(input logic [15:0] w);
    return w[15:12] == 4'hC || w[15:8] == 8'hEF || w[15:9] == 7'h76;
  endfunction : two
  function automatic int find(input logic [15:0] w);
    for (int i = 0; i < 21; i++)
      if ((w[15:8] & (i < 17 ? 8'hFC : 8'hFE)) == hi_t[i]) return i;
    return -1;
  endfunction : find
  always @(posedge sys_clk) begin
    stall <= ($urandom % 4) == 0;
    cond_true <= 1'($urandom);
    prescaler_assigned <= 1'($urandom);
  end
  // cycle model: compares what the previous edge predicted
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      st = 0; fl = 0; {e_iss, e_ss, e_rp, e_pc} = '0;
    end else begin
      chk(issue, e_iss);
      chk({shadow_save, read_from_pins, prescaler_clear}, {e_ss, e_rp, e_pc});
      if (e_iss) begin
        chk({op, flags_upd, cond_op}, {e_op, e_fl, e_cond});
        if (e_sw) begin
          chk({dest_to_reg, use_bank_sel, file_addr}, e_w[9:0]);
          chk({bit_pos, literal}, {e_w[11:9], e_w[7:0]});
          chk({branch_off_long, branch_off_short}, {e_w[10:0], e_w[7:0]});
        end
        if (e_op == OP_MOVE) chk({move_src, move_dst}, {e_f[11:0], e_w[11:0]});
        if (e_op inside {OP_GOTO, OP_CALL}) chk({jump_target, call_fast}, {e_w[11:0], e_f[7:0], e_f[8] && e_op == OP_CALL});
        if ((e_cond && cond_true) || e_op == OP_BRA) fl = 1;
      end
      {e_iss, e_ss, e_rp, e_pc, e_sw, e_cond} = '0;
      e_fl = FLG_NONE; e_op = OP_NOP;
      if (word_valid) begin
        e_w = word; idx = find(word);
        if (st == 1) begin
          e_iss = 1; st = 0;
          e_op = e_f[15:12] == 4'hC ? OP_MOVE : (e_f[9] ? OP_GOTO : OP_CALL);
          e_ss = e_op == OP_CALL && e_f[8];
        end else if (fl || st == 3) begin
          e_iss = 1; st = (st == 0 && two(word)) ? 3 : 0; fl = 0;
        end else if (two(word)) begin st = 1; e_f = word; end
        else begin
          e_iss = 1;
          if (idx >= 0) begin
            e_op = op_t[idx]; e_fl = fl_t[idx]; e_sw = 1;
            e_cond = idx inside {[10:13], [18:20]};
            qual = idx < 17 ? word[9] : idx == 17;
            e_rp = qual && !word[8] && word[7:4] == 4'h8;
            e_pc = qual && !word[8] && word[7:0] == 8'h00 && prescaler_assigned;
          end else if (word[15:11] == 5'h1A) begin e_op = OP_BRA; e_sw = 1; end
          else if (word[15:11] == 5'h1C) begin
            e_op = OP_BCOND; e_cond = 1; e_sw = 1;
          end else if (word[15:12] != 4'hF && word != 16'h0000) begin
            e_op = OP_OTHER; e_sw = 1;
          end
        end
      end
    end
  end
  task automatic gen(input int n);
    logic [31:0] r; int k;
    for (int i = 0; i < n; i++) begin
      r = $urandom; k = $urandom % 21;
      case (r[30:28])
        4: i_bod_prog_mem.q.push_back(r[27] ? {5'h1C, r[10:0]}
             : {8'h0E, r[7:0]});
        5: i_bod_prog_mem.q.push_back({4'hC, r[11:0]});
        6: i_bod_prog_mem.q.push_back({5'h1A, r[10:0]});
        7: i_bod_prog_mem.q.push_back(r[13] ? (r[12] ? {4'hF, r[11:0]} : 16'h0000)
             : (r[12] ? {7'h76, r[8:0]} : {8'hEF, r[7:0]}));
        default: i_bod_prog_mem.q.push_back({hi_t[k] | {6'h00, r[9] & (k < 17),
             r[8]}, r[2] ? r[7:0] : (r[3] ? {4'h8, r[7:4]} : 8'h00)});
      endcase
      if (two(i_bod_prog_mem.q[$])) i_bod_prog_mem.q.push_back({4'hF, r[27:16]});
    end
  endtask : gen
  task automatic drain;
    for (int i = 0; i < 20000 && i_bod_prog_mem.q.size() != 0; i++)
      @(posedge sys_clk);
    if (i_bod_prog_mem.q.size() != 0) fail_count++;
    repeat (4) @(posedge sys_clk);
  endtask : drain
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : end_of_test
  initial begin #800000; fail_count++; end_of_test; end
  initial begin
    void'($urandom(50137));
    repeat (8) @(posedge sys_clk);
    reset_n <= 1; @(posedge sys_clk);
    gen(1500); drain; $display("test 1 random stream done");
    gen(60); repeat (30) @(posedge sys_clk);
    reset_n <= 0; repeat (2) @(posedge sys_clk);
    reset_n <= 1; @(posedge sys_clk);
    gen(500); drain; $display("test 2 reset mid-run done");
    end_of_test;
  end
endmodule : bod_decoder_bench
`default_nettype wire
